// file: sepc_params.svh
// Purpose: Constants of the shaft encoder position capture block
// Assumes: 32-bit AXI4-Lite data, 8-bit byte address
// Notes:   Offsets are byte addresses
`ifndef SEPC_PARAMS_SVH
`define SEPC_PARAMS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define SEPC_OFF_CTRL    8'h00
`define SEPC_OFF_POS     8'h04
`define SEPC_OFF_LEGACY  8'h08
`define SEPC_OFF_STATUS  8'h0c

// ----------------------------------------------------------------
// Field positions, reset values and response codes
// ----------------------------------------------------------------
`define SEPC_CTRL_LEGACY_BIT  0
`define SEPC_STAT_HOLD_BIT    0
`define SEPC_STAT_READY_BIT   1
`define SEPC_POS_COARSE_LSB   7
`define SEPC_CTRL_RST         1'b0
`define SEPC_RESP_OKAY        2'b00
`define SEPC_RESP_SLVERR      2'b10

`endif

// file: sepc_pkg.sv
// Purpose: Types and shared functions of the position capture block
// Assumes: No constants from sepc_params.svh are included
// Notes:   Nothing is imported; use sepc_pkg::name
package sepc_pkg;

    // ------------------------------------------------------------
    // Position word
    // ------------------------------------------------------------
    typedef struct packed {
        logic [13:0] coarse;
        logic [6:0]  fine;
    } sepc_pos_t;

    // ------------------------------------------------------------
    // Legacy sensor group
    // ------------------------------------------------------------
    typedef struct packed {
        logic [15:0] cmp_lines;
        logic [14:0] lead;
        logic [14:0] lag;
        logic        dir;
    } sepc_legacy_in_t;

    // Gray code to natural binary
    function automatic logic [13:0] sepc_gray2bin(input logic [13:0] g);
        logic [13:0] b;
        b = '0;
        b[13] = g[13];
        for (int i = 12; i >= 0; i--) begin
            b[i] = b[i+1] ^ g[i];
        end
        return b;
    endfunction

    // Count of set lines
    function automatic logic [4:0] sepc_ones(input logic [15:0] v);
        logic [4:0] n;
        n = 5'h00;
        for (int i = 0; i < 16; i++) begin
            n = n + {4'h0, v[i]};
        end
        return n;
    endfunction

endpackage

// file: sepc_legacy_enc.sv
// Purpose: Legacy variant position word from comparator lines and sensor pairs
// Assumes: Comparator lines form a 32-state walking pattern
// Notes:   Purely combinational
`timescale 1ns/1ns
module sepc_legacy_enc (
    input  wire sepc_pkg::sepc_legacy_in_t legacy_i,
    output logic [19:0]                   word_o
);
    // ------------------------------------------------------------
    // Low bits from comparator lines
    // ------------------------------------------------------------
    wire [4:0]  ones = sepc_pkg::sepc_ones(legacy_i.cmp_lines);
    wire [4:0]  lsb  = legacy_i.cmp_lines[15] ? 5'(6'h20 - {1'b0, ones}) : ones;

    // ------------------------------------------------------------
    // Upper bits by direction
    // ------------------------------------------------------------
    wire [14:0] msb  = legacy_i.dir ? legacy_i.lead : legacy_i.lag;

    assign word_o = {msb, lsb};

endmodule // sepc_legacy_enc

// file: sepc_capture.sv
// Purpose: Shaft encoder position capture with hold handshake and AXI4-Lite view
// Assumes: All inputs synchronous to clock_i; ref period is 128 clocks
// Notes:   Position outputs change only on a phase signal rising edge
`timescale 1ns/1ns
`include "sepc_params.svh"

module sepc_capture (
    input  wire logic                      clock_i,
    input  wire logic                      rst_n_i,
    input  wire logic                      ref_i,
    input  wire logic                      phase_variable_signal_i,
    input  wire logic [13:0]               gray_tracks_i,
    input  wire sepc_pkg::sepc_legacy_in_t legacy_i,
    input  wire logic                      hold_req_i,
    output logic                           hold_o,
    output logic                           ready_o,
    output sepc_pkg::sepc_pos_t            pos_o,
    output logic [19:0]                    legacy_pos_o,
    input  wire logic [7:0]                s_axi_awaddr,
    input  wire logic                      s_axi_awvalid,
    output logic                           s_axi_awready,
    input  wire logic [31:0]               s_axi_wdata,
    input  wire logic [3:0]                s_axi_wstrb,
    input  wire logic                      s_axi_wvalid,
    output logic                           s_axi_wready,
    output logic [1:0]                     s_axi_bresp,
    output logic                           s_axi_bvalid,
    input  wire logic                      s_axi_bready,
    input  wire logic [7:0]                s_axi_araddr,
    input  wire logic                      s_axi_arvalid,
    output logic                           s_axi_arready,
    output logic [31:0]                    s_axi_rdata,
    output logic [1:0]                     s_axi_rresp,
    output logic                           s_axi_rvalid,
    input  wire logic                      s_axi_rready
);
    // ------------------------------------------------------------
    // Edge detection
    // ------------------------------------------------------------
    logic                ref_q;
    logic                phase_q;
    logic [6:0]          cnt_q;
    logic                stage2_q;
    logic                legacy_sel_q;
    logic [19:0]         legacy_word;

    wire ref_rise = ref_i & ~ref_q;
    wire phase_rise = phase_variable_signal_i & ~phase_q;
    wire phase_fall = ~phase_variable_signal_i & phase_q;
    wire strobe     = phase_rise & ~hold_o;
    wire [6:0] cnt_d = ref_rise ? 7'h00 : 7'(cnt_q + 7'h01);
    wire [13:0] coarse_bin = sepc_pkg::sepc_gray2bin(gray_tracks_i);

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ref_q   <= 1'b0;
            phase_q <= 1'b0;
            cnt_q <= 7'h00;
        end else begin
            ref_q <= ref_i;
            phase_q <= phase_variable_signal_i;
            cnt_q <= cnt_d;
        end
    end

    // ------------------------------------------------------------
    // Position registers
    // ------------------------------------------------------------
    sepc_legacy_enc u_legacy (
        .legacy_i (legacy_i),
        .word_o   (legacy_word)
    );

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pos_o        <= '0;
            legacy_pos_o <= 20'h00000;
        end else if (strobe) begin
            pos_o.fine   <= cnt_q;
            pos_o.coarse <= coarse_bin;
            if (legacy_sel_q) begin
                legacy_pos_o <= legacy_word;
            end
        end
    end

    // ------------------------------------------------------------
    // Hold synchroniser
    // ------------------------------------------------------------
    wire hold_d  = phase_fall ? hold_req_i : hold_o;
    wire stg2_d  = ~hold_req_i ? 1'b0 : (phase_fall ? hold_o : stage2_q);

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            hold_o   <= 1'b0;
            stage2_q <= 1'b0;
            ready_o  <= 1'b0;
        end else begin
            hold_o   <= hold_d;
            stage2_q <= stg2_d;
            ready_o  <= stg2_d & hold_d;
        end
    end

    // ------------------------------------------------------------
    // AXI4-Lite write
    // ------------------------------------------------------------
    logic        aw_got_q;
    logic        w_got_q;
    logic [7:0]  awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0]  wstrb_q;

    wire aw_hs    = s_axi_awvalid & s_axi_awready;
    wire w_hs     = s_axi_wvalid & s_axi_wready;
    wire b_hs     = s_axi_bvalid & s_axi_bready;
    wire wr_go    = aw_got_q & w_got_q & ~s_axi_bvalid;
    wire wr_ctrl  = awaddr_q == `SEPC_OFF_CTRL;

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            aw_got_q      <= 1'b0;
            w_got_q       <= 1'b0;
            awaddr_q      <= 8'h00;
            wdata_q       <= 32'h00000000;
            wstrb_q       <= 4'h0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `SEPC_RESP_OKAY;
            legacy_sel_q  <= `SEPC_CTRL_RST;
        end else begin
            if (aw_hs) begin
                aw_got_q      <= 1'b1;
                awaddr_q      <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (w_hs) begin
                w_got_q      <= 1'b1;
                wdata_q      <= s_axi_wdata;
                wstrb_q      <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (wr_go) begin
                aw_got_q     <= 1'b0;
                w_got_q      <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_ctrl ? `SEPC_RESP_OKAY : `SEPC_RESP_SLVERR;
                if (wr_ctrl && wstrb_q[0]) begin
                    legacy_sel_q <= wdata_q[`SEPC_CTRL_LEGACY_BIT];
                end
            end
            if (b_hs) begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // AXI4-Lite read
    // ------------------------------------------------------------
    wire ar_hs = s_axi_arvalid & s_axi_arready;
    wire r_hs  = s_axi_rvalid & s_axi_rready;
    wire sel_ctrl = s_axi_araddr == `SEPC_OFF_CTRL;
    wire sel_pos  = s_axi_araddr == `SEPC_OFF_POS;
    wire sel_leg  = s_axi_araddr == `SEPC_OFF_LEGACY;
    wire sel_stat = s_axi_araddr == `SEPC_OFF_STATUS;
    wire rd_hit   = sel_ctrl | sel_pos | sel_leg | sel_stat;
    wire [31:0] rd_mux =
        sel_ctrl ? {31'h0, legacy_sel_q} :
        sel_pos  ? {11'h000, pos_o} :
        sel_leg  ? {12'h000, legacy_pos_o} :
        sel_stat ? {30'h0, ready_o, hold_o} : 32'h00000000;

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= `SEPC_RESP_OKAY;
        end else if (ar_hs) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= rd_mux;
            s_axi_rresp   <= rd_hit ? `SEPC_RESP_OKAY : `SEPC_RESP_SLVERR;
        end else if (r_hs) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    a_cnt_restart: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        ref_rise |=> cnt_q == 7'h00)
        else $error("counter did not restart at reference rise");

    a_cnt_step: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        rst_n_i && !ref_rise |=> cnt_q == 7'($past(cnt_q) + 7'h01))
        else $error("counter did not step by one");

    a_fine_load: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        phase_rise && !hold_o |=> pos_o.fine == $past(cnt_q))
        else $error("fine bits not loaded from counter");

    a_hold_freeze: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        hold_o |=> $stable(pos_o) && $stable(legacy_pos_o))
        else $error("position changed while held");

    a_coarse_gray: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        strobe |=> pos_o.coarse == sepc_pkg::sepc_gray2bin($past(gray_tracks_i)))
        else $error("coarse bits not gray converted");

    a_coarse_with_fine: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        $changed(pos_o.coarse) |-> $past(phase_rise) && !$past(hold_o))
        else $error("coarse bits changed outside strobe");

    a_hold_on_fall: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        $changed(hold_o) |-> $past(phase_fall) && hold_o == $past(hold_req_i))
        else $error("hold changed off a falling edge");

    a_ready_after_hold: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        $rose(ready_o) |-> hold_o && $past(hold_o) && $past(phase_fall))
        else $error("ready rose before hold took effect");

    a_ready_drop: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        !hold_req_i |=> !ready_o)
        else $error("ready stayed after request withdrawn");

    a_hold_release: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        hold_o && !hold_req_i && phase_fall |=> !hold_o)
        else $error("hold not released on falling edge");

    a_bvalid_hold: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");

endmodule // sepc_capture

// file: sepc_host_model.sv
// Purpose: Host side of the hold handshake
// Assumes: Same clock as the capture block
// Notes:   Hold-inhibit is set at reset and by master clear
`timescale 1ns/1ns
module sepc_host_model (
    input  wire logic                clock_i,
    input  wire logic                rst_n_i,
    input  wire logic                start_i,
    input  wire logic                detect_i,
    input  wire logic                clear_i,
    input  wire logic                ready_i,
    input  wire sepc_pkg::sepc_pos_t pos_i,
    output logic                     hold_req_o,
    output logic                     busy_o,
    output sepc_pkg::sepc_pos_t      word_o
);
    logic inhibit_q;
    logic busy_q;
    assign hold_req_o = busy_q & ~inhibit_q;
    assign busy_o     = busy_q;
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            inhibit_q <= 1'b1;
            busy_q    <= 1'b0;
            word_o    <= '0;
        end else begin
            if (clear_i) inhibit_q <= 1'b1;
            else if (detect_i) inhibit_q <= 1'b0;
            if (start_i) busy_q <= 1'b1;
            else if (ready_i && hold_req_o) begin
                word_o <= pos_i;
                busy_q <= 1'b0;
            end
        end
    end
endmodule // sepc_host_model

// file: tb.sv
// Purpose: Self-checking bench of the position capture block
// Assumes: Host model drives the hold request
// Notes:   Phase counter checked by differences of captures
`timescale 1ns/1ns
`include "sepc_params.svh"
module tb;
    logic                       clock_i = 1'b0;
    logic                       rst_n_i, ref_i, phase_sig, hold_req_i, start, detect, clr, busy;
    logic                       hold_o, ready_o;
    logic [13:0]                gray_tracks_i;
    logic [19:0]                legacy_pos_o;
    logic [6:0]                 f1;
    sepc_pkg::sepc_pos_t        pos_o, word;
    sepc_pkg::sepc_legacy_in_t  legacy_i;
    logic [7:0]                 s_axi_awaddr, s_axi_araddr;
    logic [31:0]                s_axi_wdata, s_axi_rdata, d;
    logic [3:0]                 s_axi_wstrb;
    logic [1:0]                 s_axi_bresp, s_axi_rresp, r;
    logic                       s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic                       s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic                       s_axi_rvalid, s_axi_rready;
    int                         err_count = 0;
    int                         samples_checked = 0;

    always #5 clock_i = ~clock_i;

    sepc_capture uut (.clock_i, .rst_n_i, .ref_i, .phase_variable_signal_i(phase_sig),
        .gray_tracks_i, .legacy_i, .hold_req_i, .hold_o, .ready_o, .pos_o, .legacy_pos_o,
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready);
    sepc_host_model host (.clock_i, .rst_n_i, .start_i(start), .detect_i(detect),
        .clear_i(clr), .ready_i(ready_o), .pos_i(pos_o), .hold_req_o(hold_req_i),
        .busy_o(busy), .word_o(word));

    // ----
    // Shared tasks
    // ----
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic axw(input logic [7:0] a, input logic [31:0] wd, output logic [1:0] rs);
        @(posedge clock_i);
        s_axi_awaddr <= a;
        s_axi_wdata <= wd;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge clock_i);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while ((s_axi_awvalid && !s_axi_awready) || (s_axi_wvalid && !s_axi_wready));
        do @(posedge clock_i); while (!s_axi_bvalid);
        rs = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask

    task automatic axr(input logic [7:0] a, output logic [31:0] rd, output logic [1:0] rs);
        @(posedge clock_i);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge clock_i); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge clock_i); while (!s_axi_rvalid);
        rd = s_axi_rdata;
        rs = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask

    task automatic strobe(input int k, input logic [13:0] v);
        @(posedge clock_i);
        ref_i <= 1'b1;
        gray_tracks_i <= v ^ (v >> 1);
        repeat (k) @(posedge clock_i);
        phase_sig <= 1'b1;
        repeat (3) @(posedge clock_i);
        ref_i <= 1'b0;
        phase_sig <= 1'b0;
        repeat (4) @(posedge clock_i);
    endtask

    // ----
    // Scenarios
    // ----
    task automatic t_regs;
        axr(`SEPC_OFF_CTRL, d, r);
        chk({d, 30'h0, r}, 64'h0);
        axr(`SEPC_OFF_STATUS, d, r);
        chk(d, 32'h0);
        axr(8'h10, d, r);
        chk({d, 30'h0, r}, {32'h0, 30'h0, `SEPC_RESP_SLVERR});
        axw(`SEPC_OFF_POS, 32'hffffffff, r);
        chk(r, `SEPC_RESP_SLVERR);
        axw(`SEPC_OFF_CTRL, 32'h1, r);
        axr(`SEPC_OFF_CTRL, d, r);
        chk({d, 30'h0, r}, 64'h1_0000_0000);
    endtask

    task automatic t_count;
        strobe(2, 14'h0155);
        f1 = pos_o.fine;
        chk(pos_o.coarse, 14'h0155);
        strobe(9, 14'h2aaa);
        chk(7'(pos_o.fine - f1), 32'h7);
        chk(pos_o.coarse, 14'h2aaa);
        strobe(130, 14'h3fff);
        chk(pos_o.fine, f1);
        chk(pos_o.coarse, 14'h3fff);
        axr(`SEPC_OFF_POS, d, r);
        chk(d, {11'h0, 14'h3fff, 7'h01});
    endtask

    task automatic t_legacy;
        legacy_i <= {16'h000f, 15'h1234, 15'h0abc, 1'b1};
        strobe(3, 14'h0001);
        chk(legacy_pos_o, {15'h1234, 5'h04});
        axr(`SEPC_OFF_LEGACY, d, r);
        chk(d, {12'h0, 15'h1234, 5'h04});
        legacy_i <= {16'hfff0, 15'h1234, 15'h0abc, 1'b0};
        strobe(3, 14'h0002);
        chk(legacy_pos_o, {15'h0abc, 5'h14});
        axw(`SEPC_OFF_CTRL, 32'h0, r);
        legacy_i <= {16'h0001, 15'h7fff, 15'h7fff, 1'b1};
        strobe(3, 14'h0003);
        chk(legacy_pos_o, {15'h0abc, 5'h14});
    endtask

    task automatic t_inhibit;
        @(posedge clock_i);
        detect <= 1'b1;
        @(posedge clock_i);
        detect <= 1'b0;
        clr <= 1'b1;
        start <= 1'b1;
        @(posedge clock_i);
        clr <= 1'b0;
        start <= 1'b0;
        strobe(4, 14'h0011);
        strobe(5, 14'h0022);
        chk({hold_o, ready_o, pos_o.coarse}, {2'b00, 14'h0022});
    endtask

    task automatic t_hold;
        @(posedge clock_i);
        detect <= 1'b1;
        @(posedge clock_i);
        detect <= 1'b0;
        strobe(3, 14'h0033);
        chk({hold_o, ready_o, pos_o.coarse}, {2'b10, 14'h0033});
        axr(`SEPC_OFF_STATUS, d, r);
        chk(d, 32'h1);
        strobe(3, 14'h0044);
        chk(pos_o.coarse, 14'h0033);
        chk({busy, word.coarse}, {1'b0, 14'h0033});
        repeat (3) @(posedge clock_i);
        chk({hold_o, ready_o}, 2'b10);
        strobe(3, 14'h0055);
        chk({hold_o, pos_o.coarse}, {1'b0, 14'h0033});
        strobe(3, 14'h0066);
        chk(pos_o.coarse, 14'h0066);
    endtask

    task automatic final_report;
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    initial begin
        #100000;
        err_count++;
        final_report();
    end

    initial begin
        {rst_n_i, ref_i, phase_sig, start, detect, clr, gray_tracks_i, legacy_i} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid} = '0;
        {s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        s_axi_wstrb = 4'hf;
        repeat (10) @(posedge clock_i);
        rst_n_i <= 1'b1;
        t_regs();
        t_count();
        t_legacy();
        t_inhibit();
        t_hold();
        final_report();
    end
endmodule // tb
